// ==== inc/rcsr_pkg.sv ====
// Purpose: Shared constants for the receiver control and soft reset register bank
// Assumes: Byte-wide registers reached through the host port byte access strobes
// Notes: Offsets are byte addresses of the host register space
package rcsr_pkg;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FILT = 8'h01;
    localparam logic [7:0] OFS_VSB = 8'h03;
    localparam logic [7:0] OFS_THR_LO = 8'h21;
    localparam logic [7:0] OFS_THR_HI = 8'h22;
    localparam logic [7:0] OFS_STAGED_LAST = 8'h22;

    localparam logic [7:0] RST_CTRL = 8'h20;
    localparam logic [7:0] RST_FILT = 8'h11;
    localparam logic [7:0] RST_VSB = 8'h02;
    localparam logic [7:0] RST_THR_LO = 8'h05;
    localparam logic [7:0] RST_THR_HI = 8'h00;

    // Bits the host may change; the rest read back their reset value
    localparam logic [7:0] WMASK_FILT = 8'h3F;
    localparam logic [7:0] WMASK_VSB = 8'h10;

    localparam int BIT_REDUNDANCY = 7;
    localparam int BIT_SERIAL = 6;
    localparam int BIT_CLK_EDGE = 5;
    localparam int BIT_BYTE_POL = 4;
    localparam int BIT_ERR_POL = 3;
    localparam int BIT_PKT_POL = 2;
    localparam int BIT_DEMOD_HI = 1;
    localparam int BIT_DEMOD_LO = 0;
    localparam int BIT_SPECTRUM = 5;
    localparam int BIT_COCH_HI = 3;
    localparam int BIT_COCH_LO = 2;
    localparam int BIT_ADJ_BYP = 1;
    localparam int BIT_RESTART_DIS = 4;

    localparam logic [1:0] DEMOD_VSB8 = 2'h0;
    localparam logic [1:0] DEMOD_RSVD = 2'h1;
    localparam logic [1:0] DEMOD_QAM64 = 2'h2;
    localparam logic [1:0] DEMOD_QAM256 = 2'h3;
    localparam logic [1:0] COCH_AUTO = 2'h0;
    localparam logic [1:0] COCH_BYPASS = 2'h1;
    localparam logic [1:0] COCH_INSERT = 2'h2;

    localparam int THR_W = 16;
endpackage

// ==== inc/rcsr_cfg_if.sv ====
// Purpose: Active configuration passed from the register bank to the restart monitor
// Assumes: Single clock domain
// Notes: Bank drives the config, monitor answers with a restart request
interface rcsr_cfg_if;
    logic [1:0] demod_type;
    logic auto_restart_disable;
    logic [15:0] seg_threshold;
    logic soft_reset;
    logic restart_req;
    modport bank (output demod_type, output auto_restart_disable,
                  output seg_threshold, output soft_reset, input restart_req);
    modport monitor (input demod_type, input auto_restart_disable,
                     input seg_threshold, input soft_reset, output restart_req);
endinterface

// ==== hdl/rcsr_restart_mon.sv ====
// Purpose: Counts segment errors and requests an automatic acquisition restart in 8-VSB mode
// Assumes: Segment error strobe comes from logic on the same clock
// Notes: Count restarts at every soft reset and after every automatic restart
module rcsr_restart_mon (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic seg_error_in,
    rcsr_cfg_if.monitor cfg
);
    import rcsr_pkg::*;

    logic [THR_W-1:0] err_cnt_reg;
    logic req_reg;

    function automatic logic limit_hit(input logic [THR_W-1:0] cnt,
                                       input logic [THR_W-1:0] thr);
        // Zero threshold behaves as one so a single error can trigger
        limit_hit = (cnt + 16'h0001) >= thr;
    endfunction

    wire logic armed = (cfg.demod_type == DEMOD_VSB8) && !cfg.auto_restart_disable;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in || cfg.soft_reset || req_reg) begin
            err_cnt_reg <= 16'h0000;
        end else if (seg_error_in && err_cnt_reg != 16'hFFFF) begin
            err_cnt_reg <= err_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in || cfg.soft_reset) begin
            req_reg <= 1'b0;
        end else begin
            req_reg <= armed && seg_error_in && !req_reg &&
                       limit_hit(err_cnt_reg, cfg.seg_threshold);
        end
    end

    assign cfg.restart_req = req_reg;

    property p_no_restart_when_disabled;
        @(posedge clock_in) disable iff (sys_rst_in)
        cfg.auto_restart_disable |=> !req_reg;
    endproperty
    a_no_restart_when_disabled: assert property (p_no_restart_when_disabled)
        else $error("automatic restart raised while disabled");

    property p_restart_at_threshold;
        @(posedge clock_in) disable iff (sys_rst_in)
        (armed && seg_error_in && !req_reg && !cfg.soft_reset &&
         err_cnt_reg + 16'h0001 >= cfg.seg_threshold) |=> req_reg;
    endproperty
    a_restart_at_threshold: assert property (p_restart_at_threshold)
        else $error("threshold reached but no automatic restart");
endmodule

// ==== hdl/rcsr_regs.sv ====
// Purpose: Receiver control register bank with soft reset and staged configuration
// Assumes: Host port engine issues one-cycle byte read and write strobes
// Notes: Reads of staged registers return the written copy, not the active one
// Notes on behaviour
// - Any write to offset 00h starts a soft reset, restarting acquisition.
// - Writes to 01h through 22h act only at the next soft reset.
// - Control bit 7 adds redundancy bytes to transport output; reset zero.
// - Control bit 6 selects serial output instead of 8-bit parallel.
// - Control bit 5 selects falling output clock edge; reset one.
// - Control bit 4 makes byte-start output active low.
// - Control bit 3 makes transport error output active low.
// - Control bit 2 makes packet-start output active low.
// - Control bits 1:0 pick 8-VSB, reserved, 64-QAM or 256-QAM.
// - Register 01h bit 5 shifts spectrum negative; in QAM swaps I/Q.
// - Register 01h bits 3:2 steer co-channel filter in VSB; QAM bypasses.
// - Register 01h bit 1 bypasses adjacent filter in VSB; QAM bypasses.
// - Register 03h bit 4 suppresses automatic restart on excess segment errors.
// - Segment-error threshold is host-writable with reset value 05h.
module rcsr_regs (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic seg_error_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    output logic acquisition_restart_out,
    output logic soft_reset_out,
    output logic redundancy_output_select_out,
    output logic serial_output_select_out,
    output logic output_clock_edge_select_out,
    output logic byte_start_polarity_out,
    output logic data_error_polarity_out,
    output logic packet_start_polarity_out,
    output logic [1:0] demod_type_select_out,
    output logic spectrum_shift_select_out,
    output logic iq_swap_out,
    output logic [1:0] cochannel_filter_control_out,
    output logic adjacent_filter_bypass_out,
    output logic auto_restart_disable_out
);
    import rcsr_pkg::*;

    rcsr_cfg_if cfg_if ();

    logic [7:0] ctrl_reg;
    logic [7:0] filt_stage_reg;
    logic [7:0] vsb_stage_reg;
    logic [7:0] thr_lo_stage_reg;
    logic [7:0] thr_hi_stage_reg;
    logic [7:0] filt_act_reg;
    logic [7:0] vsb_act_reg;
    logic [15:0] thr_act_reg;
    logic soft_reset_reg;
    logic restart_reg;
    logic [1:0] coch_eff_reg;
    logic adj_byp_eff_reg;
    logic iq_swap_reg;

    function automatic logic [7:0] merge_ro(input logic [7:0] wdata,
                                            input logic [7:0] rst,
                                            input logic [7:0] wmask);
        merge_ro = (wdata & wmask) | (rst & ~wmask);
    endfunction

    function automatic logic is_qam(input logic [1:0] mode);
        is_qam = (mode == DEMOD_QAM64) || (mode == DEMOD_QAM256);
    endfunction

    wire logic wr_ctrl = reg_wr_in && (reg_addr_in == OFS_CTRL);

    // Control register is applied at once, since writing it is the soft reset
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            ctrl_reg <= RST_CTRL;
        end else if (wr_ctrl) begin
            ctrl_reg <= reg_wdata_in;
        end
    end

    // Staging copies take host writes but steer nothing until a soft reset
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            filt_stage_reg <= RST_FILT;
            vsb_stage_reg <= RST_VSB;
            thr_lo_stage_reg <= RST_THR_LO;
            thr_hi_stage_reg <= RST_THR_HI;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                OFS_FILT: begin
                    filt_stage_reg <= merge_ro(reg_wdata_in, RST_FILT, WMASK_FILT);
                end
                OFS_VSB: begin
                    vsb_stage_reg <= merge_ro(reg_wdata_in, RST_VSB, WMASK_VSB);
                end
                OFS_THR_LO: begin
                    thr_lo_stage_reg <= reg_wdata_in;
                end
                OFS_THR_HI: begin
                    thr_hi_stage_reg <= reg_wdata_in;
                end
                default: begin
                end
            endcase
        end
    end

    // Active copy loads on the same edge that raises the soft reset pulse
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            filt_act_reg <= RST_FILT;
            vsb_act_reg <= RST_VSB;
            thr_act_reg <= {RST_THR_HI, RST_THR_LO};
        end else if (wr_ctrl) begin
            filt_act_reg <= filt_stage_reg;
            vsb_act_reg <= vsb_stage_reg;
            thr_act_reg <= {thr_hi_stage_reg, thr_lo_stage_reg};
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            soft_reset_reg <= 1'b0;
            restart_reg <= 1'b0;
        end else begin
            soft_reset_reg <= wr_ctrl;
            restart_reg <= wr_ctrl || cfg_if.restart_req;
        end
    end

    // Effective filter and swap settings; QAM overrides the VSB-only controls.
    // Derived from the next-cycle sources so they change with the active copy.
    logic [1:0] mode_next;
    logic [7:0] filt_next;
    assign mode_next = wr_ctrl ? reg_wdata_in[BIT_DEMOD_HI:BIT_DEMOD_LO]
                               : ctrl_reg[BIT_DEMOD_HI:BIT_DEMOD_LO];
    assign filt_next = wr_ctrl ? filt_stage_reg : filt_act_reg;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            coch_eff_reg <= RST_FILT[BIT_COCH_HI:BIT_COCH_LO];
            adj_byp_eff_reg <= RST_FILT[BIT_ADJ_BYP];
            iq_swap_reg <= 1'b0;
        end else if (is_qam(mode_next)) begin
            coch_eff_reg <= COCH_BYPASS;
            adj_byp_eff_reg <= 1'b1;
            iq_swap_reg <= filt_next[BIT_SPECTRUM];
        end else begin
            coch_eff_reg <= filt_next[BIT_COCH_HI:BIT_COCH_LO];
            adj_byp_eff_reg <= filt_next[BIT_ADJ_BYP];
            iq_swap_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                case (reg_addr_in)
                    OFS_CTRL: reg_rdata_out <= ctrl_reg;
                    OFS_FILT: reg_rdata_out <= filt_stage_reg;
                    OFS_VSB: reg_rdata_out <= vsb_stage_reg;
                    OFS_THR_LO: reg_rdata_out <= thr_lo_stage_reg;
                    OFS_THR_HI: reg_rdata_out <= thr_hi_stage_reg;
                    default: reg_rdata_out <= 8'h00;
                endcase
            end
        end
    end

    assign cfg_if.demod_type = ctrl_reg[BIT_DEMOD_HI:BIT_DEMOD_LO];
    assign cfg_if.auto_restart_disable = vsb_act_reg[BIT_RESTART_DIS];
    assign cfg_if.seg_threshold = thr_act_reg;
    assign cfg_if.soft_reset = soft_reset_reg;

    rcsr_restart_mon u_restart_mon (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .seg_error_in(seg_error_in),
        .cfg(cfg_if.monitor)
    );

    assign soft_reset_out = soft_reset_reg;
    assign acquisition_restart_out = restart_reg;
    assign redundancy_output_select_out = ctrl_reg[BIT_REDUNDANCY];
    assign serial_output_select_out = ctrl_reg[BIT_SERIAL];
    assign output_clock_edge_select_out = ctrl_reg[BIT_CLK_EDGE];
    assign byte_start_polarity_out = ctrl_reg[BIT_BYTE_POL];
    assign data_error_polarity_out = ctrl_reg[BIT_ERR_POL];
    assign packet_start_polarity_out = ctrl_reg[BIT_PKT_POL];
    assign demod_type_select_out = ctrl_reg[BIT_DEMOD_HI:BIT_DEMOD_LO];
    assign spectrum_shift_select_out = filt_act_reg[BIT_SPECTRUM];
    assign iq_swap_out = iq_swap_reg;
    assign cochannel_filter_control_out = coch_eff_reg;
    assign adjacent_filter_bypass_out = adj_byp_eff_reg;
    assign auto_restart_disable_out = vsb_act_reg[BIT_RESTART_DIS];

    property p_soft_reset_on_write;
        @(posedge clock_in) disable iff (sys_rst_in)
        wr_ctrl |=> soft_reset_out && acquisition_restart_out;
    endproperty
    a_soft_reset_on_write: assert property (p_soft_reset_on_write)
        else $error("control write without soft reset pulse");

    property p_soft_reset_only_on_write;
        @(posedge clock_in) disable iff (sys_rst_in)
        !wr_ctrl |=> !soft_reset_out;
    endproperty
    a_soft_reset_only_on_write: assert property (p_soft_reset_only_on_write)
        else $error("soft reset pulse without control write");

    property p_staged_not_applied;
        @(posedge clock_in) disable iff (sys_rst_in)
        (reg_wr_in && reg_addr_in == OFS_FILT) |=> $stable(spectrum_shift_select_out);
    endproperty
    a_staged_not_applied: assert property (p_staged_not_applied)
        else $error("filter setting changed without soft reset");

    property p_stage_to_active;
        @(posedge clock_in) disable iff (sys_rst_in)
        wr_ctrl |=> (auto_restart_disable_out == $past(vsb_stage_reg[BIT_RESTART_DIS]))
                    && (thr_act_reg == $past({thr_hi_stage_reg, thr_lo_stage_reg}));
    endproperty
    a_stage_to_active: assert property (p_stage_to_active)
        else $error("staged copy not moved at soft reset");

    property p_ctrl_fields;
        @(posedge clock_in) disable iff (sys_rst_in)
        wr_ctrl |=> redundancy_output_select_out == $past(reg_wdata_in[7])
                    && serial_output_select_out == $past(reg_wdata_in[6])
                    && packet_start_polarity_out == $past(reg_wdata_in[2])
                    && demod_type_select_out == $past(reg_wdata_in[1:0]);
    endproperty
    a_ctrl_fields: assert property (p_ctrl_fields)
        else $error("control field outputs do not follow written value");

    property p_qam_bypass;
        @(posedge clock_in) disable iff (sys_rst_in)
        (wr_ctrl && reg_wdata_in[1]) |=>
            cochannel_filter_control_out == COCH_BYPASS && adjacent_filter_bypass_out
            && iq_swap_out == spectrum_shift_select_out;
    endproperty
    a_qam_bypass: assert property (p_qam_bypass)
        else $error("QAM mode did not bypass the VSB filters");

    property p_reserved_bits;
        @(posedge clock_in) disable iff (sys_rst_in)
        (reg_rd_in && reg_addr_in == OFS_VSB) |=> (reg_rdata_out & ~WMASK_VSB) == RST_VSB;
    endproperty
    a_reserved_bits: assert property (p_reserved_bits)
        else $error("reserved bits of restart register read wrong");

    property p_threshold_reset;
        @(posedge clock_in)
        sys_rst_in |=> thr_lo_stage_reg == RST_THR_LO && thr_act_reg[7:0] == RST_THR_LO;
    endproperty
    a_threshold_reset: assert property (p_threshold_reset)
        else $error("segment error threshold reset value wrong");
endmodule

// ==== tb/rcsr_host_model.sv ====
// Purpose: Host side of the register port, issuing byte read and write strobes
// Assumes: Strobes change 1 ns after the rising clock edge
// Notes: Fills the reserved bits of 01h and 03h with the values the host must write
module rcsr_host_model (
    input wire logic clock_in,
    input wire logic [7:0] reg_rdata_in,
    input wire logic reg_rvalid_in,
    output logic reg_wr_out,
    output logic reg_rd_out,
    output logic [7:0] reg_addr_out,
    output logic [7:0] reg_wdata_out
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_addr_out = 8'h00;
        reg_wdata_out = 8'h00;
    end

    // Leading edge wait leaves an idle cycle, so no strobe is driven twice in one step
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] v;
        v = data;
        if (addr == 8'h01) begin
            v = v | 8'h11;
        end
        if (addr == 8'h03) begin
            v = {v[7:4], 4'h2};
        end
        @(posedge clock_in);
        #1;
        reg_addr_out = addr;
        reg_wdata_out = v;
        reg_wr_out = 1'b1;
        @(posedge clock_in);
        #1;
        reg_wr_out = 1'b0;
    endtask

    // Settings and channel changes are always followed by this
    task automatic soft_reset(input logic [7:0] ctrl);
        write_reg(8'h00, ctrl);
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output bit ok);
        @(posedge clock_in);
        #1;
        reg_addr_out = addr;
        reg_rd_out = 1'b1;
        @(posedge clock_in);
        #1;
        reg_rd_out = 1'b0;
        ok = 1'b0;
        data = 8'h00;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (reg_rvalid_in === 1'b1) begin
                ok = 1'b1;
                data = reg_rdata_in;
            end else begin
                @(posedge clock_in);
                #1;
            end
        end
    endtask
endmodule

// ==== tb/rcsr_regs_tb.sv ====
// Purpose: Self-checking bench for the receiver control register bank
// Assumes: Host model drives the register port; bench drives segment errors
// Notes: Expected values come from the package constants and bit layout
module rcsr_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic clock_in, sys_rst_in, seg_error_in;
    logic reg_wr, reg_rd, rvalid, acq, srst, red, ser, edg, bpol, epol, ppol;
    logic spec, iq, adj, ard;
    logic [7:0] addr, wdata, rdata;
    logic [1:0] demod, coch;
    logic [7:0] ctrl_o;
    logic [3:0] deriv_o;
    logic [7:0] ctrl_tab [11] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04,
                                   8'h00, 8'h01, 8'h02, 8'h03, 8'hC3};
    int mismatches = 0;
    int checked = 0;

    assign ctrl_o = {red, ser, edg, bpol, epol, ppol, demod};
    assign deriv_o = {iq, coch, adj};

    rcsr_host_model host (.clock_in(clock_in), .reg_rdata_in(rdata),
        .reg_rvalid_in(rvalid), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
        .reg_addr_out(addr), .reg_wdata_out(wdata));

    rcsr_regs uut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .seg_error_in(seg_error_in), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .acquisition_restart_out(acq), .soft_reset_out(srst),
        .redundancy_output_select_out(red), .serial_output_select_out(ser),
        .output_clock_edge_select_out(edg), .byte_start_polarity_out(bpol),
        .data_error_polarity_out(epol), .packet_start_polarity_out(ppol),
        .demod_type_select_out(demod), .spectrum_shift_select_out(spec),
        .iq_swap_out(iq), .cochannel_filter_control_out(coch),
        .adjacent_filter_bypass_out(adj), .auto_restart_disable_out(ard));

    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        bit ok;
        host.read_reg(a, d, ok);
        if (!ok) begin
            check(16'h0000, 16'h0001);
            summarize();
        end else begin
            check({8'h00, d}, {8'h00, exp});
        end
    endtask

    // Waits a bounded number of cycles for the restart pulse; 0 means none seen.
    // Restart shows one cycle after the edge that samples the last error, the first edge the loop samples.
    task automatic seg_errors(input int n, input int exp_k);
        int k;
        @(posedge clock_in);
        #1;
        seg_error_in = 1'b1;
        repeat (n) @(posedge clock_in);
        #1;
        seg_error_in = 1'b0;
        k = 0;
        for (int i = 1; i <= 6 && k == 0; i++) begin
            @(posedge clock_in);
            #1;
            if (acq === 1'b1) k = i;
        end
        check(k[15:0], exp_k[15:0]);
    endtask

    initial begin
        sys_rst_in = 1'b1;
        seg_error_in = 1'b0;
        repeat (4) @(posedge clock_in);
        #1;
        sys_rst_in = 1'b0;
        rd_check(rcsr_pkg::OFS_CTRL, rcsr_pkg::RST_CTRL);
        rd_check(rcsr_pkg::OFS_FILT, rcsr_pkg::RST_FILT);
        rd_check(rcsr_pkg::OFS_VSB, rcsr_pkg::RST_VSB);
        rd_check(rcsr_pkg::OFS_THR_LO, rcsr_pkg::RST_THR_LO);
        rd_check(rcsr_pkg::OFS_THR_HI, rcsr_pkg::RST_THR_HI);
        check({8'h00, ctrl_o}, {8'h00, rcsr_pkg::RST_CTRL});
        check({spec, deriv_o, srst, acq, ard}, 8'h00);
        $display("test reset_values done");

        host.write_reg(rcsr_pkg::OFS_FILT, 8'h28);
        rd_check(rcsr_pkg::OFS_FILT, 8'h39);
        check({spec, deriv_o}, 5'h00);
        host.soft_reset(rcsr_pkg::RST_CTRL);
        check({srst, acq}, 2'b11);
        check({spec, deriv_o}, 5'h14);
        @(posedge clock_in);
        #1;
        check({srst, acq}, 2'b00);
        $display("test staged_apply done");

        foreach (ctrl_tab[i]) begin
            host.soft_reset(ctrl_tab[i]);
            check({8'h00, ctrl_o}, {8'h00, ctrl_tab[i]});
            check(deriv_o, ctrl_tab[i][1] ? 4'b1011 : 4'b0100);
        end
        rd_check(rcsr_pkg::OFS_CTRL, 8'hC3);
        $display("test control_fields done");

        host.write_reg(rcsr_pkg::OFS_FILT, 8'hFF);
        rd_check(rcsr_pkg::OFS_FILT, 8'h3F);
        host.write_reg(rcsr_pkg::OFS_VSB, 8'hF0);
        rd_check(rcsr_pkg::OFS_VSB, 8'h12);
        host.write_reg(8'h02, 8'hA5);
        rd_check(8'h02, 8'h00);
        $display("test reserved_bits done");

        host.write_reg(rcsr_pkg::OFS_VSB, 8'h00);
        host.write_reg(rcsr_pkg::OFS_THR_LO, 8'h03);
        host.write_reg(rcsr_pkg::OFS_THR_HI, 8'h00);
        host.soft_reset(8'h20);
        check(ard, 1'b0);
        seg_errors(2, 0);
        seg_errors(1, 1);
        host.soft_reset(8'h22);
        seg_errors(3, 0);
        host.write_reg(rcsr_pkg::OFS_VSB, 8'h10);
        host.soft_reset(8'h20);
        check(ard, 1'b1);
        seg_errors(3, 0);
        $display("test auto_restart done");
        summarize();
    end
endmodule
